// [plcm_flags_port.sv]
// processor flag, status and data window of the power-line mac
// What this block does
// (RQ1) bypass stops mac, cpu drives modem
// (RQ2) strict preamble: any bit error drops
// (RQ3) tolerant preamble: drop above error limit
// (RQ4) end marker then two check bytes
// (RQ5) cpu sets marker only where needed
// (RQ6) fec fields delivered when enabled
// (RQ7) each received byte sets rx flag
// (RQ8) cpu clears rx flag after reading
// (RQ9) sent check byte also sets rx
// (RQ10) tx flag handshake, mac clears it
// (RQ11) soft score: distance to 0 or 7
// (RQ12) hard score: 7 on mismatch
// (RQ13) protected header affects reception only
// (RQ14) separate or summed header thresholds
// (RQ15) done flag set, cleared by abort
// (RQ16) header index with first byte only
// (RQ17) four header patterns reset defaults
// (RQ18) check sequence error flag
// (RQ19) block code error flag
// (RQ20) window carries bytes and header programming
// (RQ21) fec field in bits five..zero
// (RQ22) null mode fec bits inverted
// (RQ23) abort cycle resets logic, keeps config
// (RQ24) preamble of one to four nibbles
// (RQ25) reserved bits read zero
`include "plcm_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module plcm_flags_port #(
  parameter int ADDR_W = 16
) (
  input  wire logic                MCLK,
  input  wire logic                ARST_N,
  input  wire logic [ADDR_W-1:0]   BUS_ADDR,
  input  wire logic [7:0]          BUS_WDATA,
  input  wire logic                BUS_WR,
  input  wire logic                BUS_RD,
  output var  logic [7:0]          BUS_RDATA,
  input  wire logic                CTRL_STOP,
  input  wire logic                CTRL_RX_MODE,
  input  wire logic [1:0]          CTRL_PRE_LEN,
  input  wire logic                CTRL_FCS_MODE,
  input  wire logic                CTRL_FEC_MODE,
  input  wire logic                CTRL_NULL_MODE,
  input  wire logic                CTRL_HEADER_PROGRAM_MODE,
  input  wire logic                CTRL_TXIE,
  input  wire logic [5:0]          PREAMBLE_ERROR_LIMIT,
  input  wire logic [7:0]          HEADER_ERROR_LIMIT,
  input  wire logic                MODEM_RX_STROBE,
  input  wire logic [2:0]          MODEM_RX_LEVEL,
  input  wire logic                MODEM_TX_TICK,
  input  wire logic [15:0]         TX_CHECK_WORD,
  input  wire logic                CHECK_SEQ_FAIL,
  input  wire logic                BLOCK_CODE_FAIL,
  output var  logic                MODEM_TX_BIT,
  output var  logic                MODEM_TX_ACTIVE,
  output var  logic                EXT_INTERRUPT_LINE
);
  if (ADDR_W != 16) begin : g_bad_addr
    $error("ADDR_W must be 16");
  end

  // (RQ11) soft or hard bit score
  function automatic logic [2:0] bit_err(input logic [2:0] lv, input logic ex,
                                         input logic hard);
    if (hard) begin
      // (RQ12) mismatch scores 7
      bit_err = (lv[2] != ex) ? `PLCM_LVL_MAX : 3'h0;
    end else begin
      bit_err = ex ? (`PLCM_LVL_MAX - lv) : lv;
    end
  endfunction

  plcm_pkg::plcm_rx_e rx_st_reg, rx_st_next;
  plcm_pkg::plcm_tx_e tx_st_reg, tx_st_next;
  logic [7:0]  pri_reg, pri_next, sec_reg, sec_next, win_reg, win_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic [15:0] hdr_reg [4];
  logic [15:0] hdr_next [4];
  logic [7:0]  herr_reg [4];
  logic [7:0]  herr_next [4];
  logic [2:0]  hp_ptr_reg, hp_ptr_next;
  logic [4:0]  rx_cnt_reg, rx_cnt_next;
  logic [6:0]  perr_reg, perr_next;
  logic [7:0]  rxsh_reg, rxsh_next;
  logic [1:0]  hidx_reg, hidx_next, cs_cnt_reg, cs_cnt_next, cs_idx_reg, cs_idx_next;
  logic        first_reg, first_next, cs_act_reg, cs_act_next;
  logic [7:0]  txsh_reg, txsh_next;
  logic [3:0]  tx_cnt_reg, tx_cnt_next;
  logic        fec_nx_reg, fec_nx_next, txb_reg, txb_next, irq_reg, irq_next;
  logic        act_reg, act_next;

  logic        mac_on, rx_on, tx_on, hsh, acc_eff, bit_in, pri_wr, win_wr;
  logic [4:0]  pre_total;
  logic [6:0]  perr_inc;
  logic [5:0]  fec_word;

  // (RQ1) bypass or abort holds the mac off
  assign mac_on    = ~pri_reg[`PLCM_B_BYP] & ~CTRL_STOP;
  // (RQ13) protected header used in reception only
  assign rx_on     = mac_on & CTRL_RX_MODE & ~CTRL_HEADER_PROGRAM_MODE;
  assign tx_on     = mac_on & ~CTRL_RX_MODE & ~CTRL_HEADER_PROGRAM_MODE;
  assign hsh       = sec_reg[`PLCM_B_HSH];
  assign acc_eff   = sec_reg[`PLCM_B_ACC] & ~hsh;
  assign bit_in    = MODEM_RX_LEVEL[2];
  // (RQ24) four bits per preamble nibble
  assign pre_total = {1'b0, CTRL_PRE_LEN, 2'b00} + 5'h4;
  // expected preamble bit alternates 1,0 from the start
  assign perr_inc  = perr_reg + {6'h0, bit_in == rx_cnt_reg[0]};
  assign fec_word  = {rxsh_reg[4:0], bit_in};
  assign pri_wr    = BUS_WR && BUS_ADDR == `PLCM_A_PRI;
  assign win_wr    = BUS_WR && BUS_ADDR == `PLCM_A_WIN;

  always_comb begin
    logic [3:0] di;
    logic       isd, last, hit, rx_set, tx_clr;
    logic [1:0] idx;
    logic [8:0] score;
    logic [7:0] byte_in;
    di = 4'h0; isd = 1'b0; last = 1'b0; hit = 1'b0; rx_set = 1'b0; tx_clr = 1'b0;
    idx = 2'h0; score = 9'h0; byte_in = {rxsh_reg[6:0], bit_in};
    pri_next = pri_reg; sec_next = sec_reg; win_next = win_reg;
    hdr_next = hdr_reg; herr_next = herr_reg; hp_ptr_next = hp_ptr_reg;
    rx_st_next = rx_st_reg; rx_cnt_next = rx_cnt_reg; perr_next = perr_reg;
    rxsh_next = rxsh_reg; hidx_next = hidx_reg; first_next = first_reg;
    cs_act_next = cs_act_reg; cs_cnt_next = cs_cnt_reg; cs_idx_next = cs_idx_reg;
    tx_st_next = tx_st_reg; txsh_next = txsh_reg; tx_cnt_next = tx_cnt_reg;
    fec_nx_next = fec_nx_reg; txb_next = txb_reg;
    rdata_next = rdata_reg;

    // (RQ25) reserved bits never stored
    if (pri_wr) pri_next = BUS_WDATA & `PLCM_PRI_WM;
    if (BUS_WR && BUS_ADDR == `PLCM_A_SEC) sec_next[7:5] = BUS_WDATA[7:5];
    if (win_wr) begin
      win_next = BUS_WDATA;
      // (RQ20) window writes program header bytes
      if (CTRL_HEADER_PROGRAM_MODE && !pri_reg[`PLCM_B_BYP]) begin
        if (hp_ptr_reg[0]) hdr_next[hp_ptr_reg[2:1]][7:0] = BUS_WDATA;
        else hdr_next[hp_ptr_reg[2:1]][15:8] = BUS_WDATA;
        hp_ptr_next = hp_ptr_reg + 3'h1;
      end
    end

    unique case (rx_st_reg)
      plcm_pkg::RX_HUNT: if (MODEM_RX_STROBE && bit_in) begin
        rx_st_next = plcm_pkg::RX_PRE;
        rx_cnt_next = 5'h1;
        perr_next = 7'h0;
      end
      plcm_pkg::RX_PRE: if (MODEM_RX_STROBE) begin
        perr_next = perr_inc;
        rx_cnt_next = rx_cnt_reg + 5'h1;
        // (RQ2) strict: one bad bit drops
        if (!pri_reg[`PLCM_B_TOL] && perr_inc != 7'h0) rx_st_next = plcm_pkg::RX_HUNT;
        // (RQ3) tolerant: drop above limit
        else if (pri_reg[`PLCM_B_TOL] && !acc_eff && perr_inc > {1'b0, PREAMBLE_ERROR_LIMIT})
          rx_st_next = plcm_pkg::RX_HUNT;
        else if (rx_cnt_reg == pre_total - 5'h1) begin
          rx_st_next = plcm_pkg::RX_HDR;
          rx_cnt_next = 5'h0;
          for (int i = 0; i < 4; i++) herr_next[i] = 8'h0;
        end
      end
      plcm_pkg::RX_HDR: if (MODEM_RX_STROBE) begin
        if (!hsh) begin
          isd = 1'b1;
          di = rx_cnt_reg[3:0];
          last = rx_cnt_reg == `PLCM_HDR_END;
        end else begin
          // protected header: fec fields skipped, correction lives elsewhere
          isd = rx_cnt_reg < 5'h8 || (rx_cnt_reg >= 5'he && rx_cnt_reg < 5'h16);
          di = rx_cnt_reg < 5'h8 ? rx_cnt_reg[3:0] : 4'(rx_cnt_reg - 5'h6);
          last = rx_cnt_reg == `PLCM_SHD_END;
        end
        if (isd) begin
          for (int i = 0; i < 4; i++)
            herr_next[i] = herr_reg[i] + {5'h0, bit_err(MODEM_RX_LEVEL,
                                   hdr_reg[i][4'hf - di], sec_reg[`PLCM_B_HEADER_DECISION_SELECT] | hsh)};
        end
        rx_cnt_next = rx_cnt_reg + 5'h1;
        if (last) begin
          // (RQ14) summed or separate thresholds, lowest index wins
          for (int i = 3; i >= 0; i--) begin
            score = {1'b0, herr_next[i]} + (acc_eff ? {2'b00, perr_reg} : 9'h0);
            if (score <= {1'b0, HEADER_ERROR_LIMIT}) begin
              hit = 1'b1;
              idx = 2'(i);
            end
          end
          rx_st_next = hit ? plcm_pkg::RX_DATA : plcm_pkg::RX_HUNT;
          rx_cnt_next = 5'h0;
          hidx_next = idx;
          first_next = 1'b1;
          cs_act_next = 1'b0;
          cs_cnt_next = 2'h0;
        end
      end
      plcm_pkg::RX_DATA: if (MODEM_RX_STROBE) begin
        rxsh_next = byte_in;
        rx_cnt_next = rx_cnt_reg + 5'h1;
        if (rx_cnt_reg == 5'h7) begin
          // (RQ7) byte delivered, flag raised
          win_next = byte_in;
          rx_set = 1'b1;
          rx_cnt_next = 5'h0;
          // (RQ16) index shown with first byte
          if (first_reg) begin
            sec_next[`PLCM_B_HD +: 2] = hidx_reg;
            first_next = 1'b0;
          end
          // (RQ4) marker turns next two bytes into check sequence
          if (cs_act_reg) cs_cnt_next = cs_cnt_reg + 2'h1;
          else if (pri_reg[`PLCM_B_END] && CTRL_FCS_MODE) cs_act_next = 1'b1;
          if (CTRL_FEC_MODE || CTRL_NULL_MODE) rx_st_next = plcm_pkg::RX_FEC;
          else if (cs_act_reg && cs_cnt_reg == 2'h1) rx_st_next = plcm_pkg::RX_END;
        end
      end
      plcm_pkg::RX_FEC: if (MODEM_RX_STROBE) begin
        rxsh_next = byte_in;
        rx_cnt_next = rx_cnt_reg + 5'h1;
        if (rx_cnt_reg == 5'h5) begin
          rx_cnt_next = 5'h0;
          // (RQ22) null mode hands fec inverted
          if (CTRL_NULL_MODE) begin
            win_next = {2'b00, ~fec_word};
            rx_set = 1'b1;
          // (RQ6) fec delivered on request (RQ21) low six bits
          end else if (pri_reg[`PLCM_B_FECD]) begin
            win_next = {2'b00, fec_word};
            rx_set = 1'b1;
          end
          rx_st_next = (cs_act_reg && cs_cnt_reg == 2'h2) ? plcm_pkg::RX_END
                                                           : plcm_pkg::RX_DATA;
        end
      end
      plcm_pkg::RX_END: rx_st_next = plcm_pkg::RX_END;
      default: rx_st_next = plcm_pkg::RX_HUNT;
    endcase
    if (!rx_on) rx_st_next = plcm_pkg::RX_HUNT;

    unique case (tx_st_reg)
      plcm_pkg::TX_IDLE: if (tx_on) begin
        // (RQ10) byte taken, flag cleared for the next one
        if (pri_reg[`PLCM_B_TX]) begin
          txsh_next = fec_nx_reg ? {~win_reg[5:0], 2'b00} : win_reg;
          tx_cnt_next = fec_nx_reg ? 4'h6 : 4'h8;
          fec_nx_next = CTRL_NULL_MODE & ~fec_nx_reg;
          tx_clr = 1'b1;
          tx_st_next = plcm_pkg::TX_SHIFT;
        // (RQ9) check bytes shown to the cpu as sent
        end else if (pri_reg[`PLCM_B_END] && CTRL_FCS_MODE && cs_idx_reg != 2'h2) begin
          txsh_next = cs_idx_reg[0] ? TX_CHECK_WORD[7:0] : TX_CHECK_WORD[15:8];
          win_next = txsh_next;
          rx_set = 1'b1;
          cs_idx_next = cs_idx_reg + 2'h1;
          tx_cnt_next = 4'h8;
          tx_st_next = plcm_pkg::TX_SHIFT;
        end else if (pri_reg[`PLCM_B_END]) begin
          // (RQ15) transmission finished
          sec_next[`PLCM_B_DONE] = 1'b1;
          tx_st_next = plcm_pkg::TX_END;
        end
      end
      plcm_pkg::TX_SHIFT: if (MODEM_TX_TICK) begin
        txb_next = txsh_reg[7];
        txsh_next = {txsh_reg[6:0], 1'b0};
        tx_cnt_next = tx_cnt_reg - 4'h1;
        if (tx_cnt_reg == 4'h1) tx_st_next = plcm_pkg::TX_IDLE;
      end
      plcm_pkg::TX_END: tx_st_next = plcm_pkg::TX_END;
      default: tx_st_next = plcm_pkg::TX_IDLE;
    endcase
    if (!tx_on) tx_st_next = plcm_pkg::TX_IDLE;
    // active pin from its own flop, no decode glitch
    act_next = tx_st_next == plcm_pkg::TX_SHIFT;
    // (RQ1) bypass: cpu drives modem bit directly
    if (pri_reg[`PLCM_B_BYP]) txb_next = win_reg[0];

    // sw write of tx wins over the hw clear; hw rx set wins over sw clear
    if (tx_clr && !pri_wr) pri_next[`PLCM_B_TX] = 1'b0;
    pri_next[`PLCM_B_RX] = pri_next[`PLCM_B_RX] | rx_set;
    // (RQ18) check sequence error
    if (rx_on && CHECK_SEQ_FAIL) sec_next[`PLCM_B_CSE] = 1'b1;
    // (RQ19) block code error
    if (rx_on && BLOCK_CODE_FAIL) sec_next[`PLCM_B_BCE] = 1'b1;

    // (RQ23) abort resets mac state, config kept
    if (CTRL_STOP) begin
      pri_next[`PLCM_B_RX] = 1'b0;
      pri_next[`PLCM_B_TX] = 1'b0;
      pri_next[`PLCM_B_END] = 1'b0;
      sec_next[4:0] = 5'h0;
      hp_ptr_next = 3'h0;
      cs_idx_next = 2'h0;
      fec_nx_next = 1'b0;
    end

    if (BUS_RD) begin
      unique case (BUS_ADDR)
        `PLCM_A_PRI: rdata_next = pri_reg;
        `PLCM_A_SEC: rdata_next = sec_reg;
        `PLCM_A_WIN: rdata_next = pri_reg[`PLCM_B_BYP] ? {5'h0, MODEM_RX_LEVEL} : win_reg;
        default:     rdata_next = 8'h00;
      endcase
    end
    // tx-side alerts only reach the line when enabled
    irq_next = pri_next[`PLCM_B_RX] & (CTRL_RX_MODE | CTRL_TXIE);
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pri_reg <= `PLCM_PRI_RST;
      sec_reg <= `PLCM_SEC_RST;
      win_reg <= `PLCM_WIN_RST;
      // (RQ17) header pattern defaults
      hdr_reg[0] <= `PLCM_HDR0;
      hdr_reg[1] <= `PLCM_HDR1;
      hdr_reg[2] <= `PLCM_HDR2;
      hdr_reg[3] <= `PLCM_HDR3;
      for (int i = 0; i < 4; i++) herr_reg[i] <= 8'h0;
      hp_ptr_reg <= 3'h0;
      rx_st_reg <= plcm_pkg::RX_HUNT;
      rx_cnt_reg <= 5'h0;
      perr_reg <= 7'h0;
      rxsh_reg <= 8'h0;
      hidx_reg <= 2'h0;
      first_reg <= 1'b0;
      cs_act_reg <= 1'b0;
      cs_cnt_reg <= 2'h0;
      cs_idx_reg <= 2'h0;
      tx_st_reg <= plcm_pkg::TX_IDLE;
      txsh_reg <= 8'h0;
      tx_cnt_reg <= 4'h0;
      fec_nx_reg <= 1'b0;
      txb_reg <= 1'b0;
      irq_reg <= 1'b0;
      act_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      pri_reg <= pri_next;
      sec_reg <= sec_next;
      win_reg <= win_next;
      hdr_reg <= hdr_next;
      herr_reg <= herr_next;
      hp_ptr_reg <= hp_ptr_next;
      rx_st_reg <= rx_st_next;
      rx_cnt_reg <= rx_cnt_next;
      perr_reg <= perr_next;
      rxsh_reg <= rxsh_next;
      hidx_reg <= hidx_next;
      first_reg <= first_next;
      cs_act_reg <= cs_act_next;
      cs_cnt_reg <= cs_cnt_next;
      cs_idx_reg <= cs_idx_next;
      tx_st_reg <= tx_st_next;
      txsh_reg <= txsh_next;
      tx_cnt_reg <= tx_cnt_next;
      fec_nx_reg <= fec_nx_next;
      txb_reg <= txb_next;
      irq_reg <= irq_next;
      act_reg <= act_next;
      rdata_reg <= rdata_next;
    end
  end

  assign BUS_RDATA          = rdata_reg;
  assign MODEM_TX_BIT       = txb_reg;
  assign MODEM_TX_ACTIVE    = act_reg;
  assign EXT_INTERRUPT_LINE = irq_reg;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  bypass_hold_a: assert property (pri_reg[`PLCM_B_BYP] |=> // RQ1
    rx_st_reg == plcm_pkg::RX_HUNT && tx_st_reg == plcm_pkg::TX_IDLE)
    else $error("mac active in bypass");
  strict_drop_a: assert property (rx_on && !pri_reg[`PLCM_B_TOL] && // RQ2
    rx_st_reg == plcm_pkg::RX_PRE && MODEM_RX_STROBE && bit_in == rx_cnt_reg[0]
    |=> rx_st_reg == plcm_pkg::RX_HUNT) else $error("bad preamble bit kept");
  tol_keep_a: assert property (rx_on && pri_reg[`PLCM_B_TOL] && !acc_eff && // RQ3
    rx_st_reg == plcm_pkg::RX_PRE && MODEM_RX_STROBE && rx_cnt_reg != pre_total - 5'h1
    && perr_inc <= {1'b0, PREAMBLE_ERROR_LIMIT} |=> rx_st_reg == plcm_pkg::RX_PRE)
    else $error("tolerated preamble dropped");
  rx_flag_a: assert property (rx_on && rx_st_reg == plcm_pkg::RX_DATA && // RQ7
    MODEM_RX_STROBE && rx_cnt_reg == 5'h7 |=> pri_reg[`PLCM_B_RX]
    && win_reg == $past({rxsh_reg[6:0], bit_in})) else $error("byte not delivered");
  cs_show_a: assert property (tx_on && tx_st_reg == plcm_pkg::TX_IDLE && // RQ9
    !pri_reg[`PLCM_B_TX] && pri_reg[`PLCM_B_END] && CTRL_FCS_MODE && cs_idx_reg == 2'h0
    |=> pri_reg[`PLCM_B_RX] && win_reg == $past(TX_CHECK_WORD[15:8]))
    else $error("check byte not shown");
  tx_take_a: assert property (tx_on && tx_st_reg == plcm_pkg::TX_IDLE && // RQ10
    pri_reg[`PLCM_B_TX] && !pri_wr |=> !pri_reg[`PLCM_B_TX]
    && tx_st_reg == plcm_pkg::TX_SHIFT) else $error("tx byte not taken");
  done_sticky_a: assert property (sec_reg[`PLCM_B_DONE] && !CTRL_STOP // RQ15
    |=> sec_reg[`PLCM_B_DONE]) else $error("done flag lost");
  hdr_quiet_a: assert property (rx_st_reg == plcm_pkg::RX_HDR && !win_wr // RQ16
    |=> $stable(win_reg)) else $error("header byte forwarded");
  null_inv_a: assert property (rx_on && CTRL_NULL_MODE && // RQ22
    rx_st_reg == plcm_pkg::RX_FEC && MODEM_RX_STROBE && rx_cnt_reg == 5'h5
    |=> win_reg == {2'b00, ~$past(fec_word)}) else $error("null fec not inverted");
  reserved_a: assert property (pri_reg[6:5] == 2'b00) // RQ25
    else $error("reserved bits set");
endmodule
`default_nettype wire

// [plcm_defines.svh]
// register map, field positions, reset values and header defaults
`ifndef PLCM_DEFINES_SVH
`define PLCM_DEFINES_SVH
`define PLCM_A_PRI   16'hfe01
`define PLCM_A_SEC   16'hfe02
`define PLCM_A_WIN   16'hfe03
`define PLCM_B_BYP   7
`define PLCM_B_TOL   4
`define PLCM_B_END   3
`define PLCM_B_FECD  2
`define PLCM_B_RX    1
`define PLCM_B_TX    0
`define PLCM_B_HEADER_DECISION_SELECT  7
`define PLCM_B_HSH   6
`define PLCM_B_ACC   5
`define PLCM_B_DONE  4
`define PLCM_B_HD    2
`define PLCM_B_CSE   1
`define PLCM_B_BCE   0
`define PLCM_PRI_RST 8'h10
`define PLCM_SEC_RST 8'h00
`define PLCM_WIN_RST 8'h00
`define PLCM_PRI_WM  8'h9f
`define PLCM_HDR0    16'h9b58
`define PLCM_HDR1    16'he958
`define PLCM_HDR2    16'h24e7
`define PLCM_HDR3    16'ha5d8
`define PLCM_LVL_MAX 3'h7
`define PLCM_HDR_END 5'hf
`define PLCM_SHD_END 5'h1b
`endif

// [plcm_pkg.sv]
// state types of the flag and data port
package plcm_pkg;
  typedef enum logic [2:0] {
    RX_HUNT = 3'b000,
    RX_PRE  = 3'b001,
    RX_HDR  = 3'b010,
    RX_DATA = 3'b011,
    RX_FEC  = 3'b100,
    RX_END  = 3'b101
  } plcm_rx_e;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SHIFT = 2'b01,
    TX_END   = 2'b10
  } plcm_tx_e;
endpackage

// [plcm_cpu_model.sv]
// processor bus model for the mac flag and data port
`timescale 1ns/10ps
`default_nettype none
module plcm_cpu_model (
  input  wire logic        mclk,
  output var  logic [15:0] bus_addr,
  output var  logic [7:0]  bus_wdata,
  output var  logic        bus_wr,
  output var  logic        bus_rd,
  output var  logic        ctrl_stop,
  input  wire logic [7:0]  bus_rdata
);
  initial begin
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    ctrl_stop = 1'b1;
  end
  // released bus shows inverted values so stale data cannot pass
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge mclk);
    #1;
    bus_wr = 1'b0;
    bus_addr = ~a;
    bus_wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge mclk);
    #1;
    bus_rd = 1'b0;
    bus_addr = ~a;
    d = bus_rdata;
  endtask
  task automatic stop_cycle();
    @(posedge mclk);
    #1;
    ctrl_stop = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    ctrl_stop = 1'b0;
  endtask
  // read window first, then clear rx
  task automatic rx_take(input logic [7:0] cfg, output logic [7:0] d);
    rd(16'hfe03, d);
    wr(16'hfe01, cfg);
  endtask
  // window written only while tx is clear, then tx set
  task automatic tx_put(input logic [7:0] cfg, input logic [7:0] d, output logic ok);
    logic [7:0] f;
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      rd(16'hfe01, f);
      ok = (f[0] === 1'b0);
    end
    if (ok) begin
      wr(16'hfe03, d);
      wr(16'hfe01, cfg | 8'h01);
    end
  endtask
endmodule
`default_nettype wire

// [plcm_flags_port_test.sv]
// self-checking bench for the mac flag, status and data port
`timescale 1ns/10ps
`default_nettype none
module plcm_flags_port_test;
  logic        mclk;
  logic        arst_n;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [7:0]  bus_rdata;
  logic        ctrl_stop;
  logic        rx_mode;
  logic        fcs_mode;
  logic        fec_mode;
  logic        null_mode;
  logic        txie;
  logic [5:0]  pre_lim;
  logic [7:0]  hdr_lim;
  logic        rx_strobe;
  logic [2:0]  rx_level;
  logic        tx_tick;
  logic        cs_fail;
  logic        bc_fail;
  logic        tx_bit;
  logic        tx_active;
  logic        irq;
  logic [7:0]  d;
  logic        ok;
  int          n_mismatch;
  int          checks_done;
  logic [15:0] hdr_tab [4];
  logic [1:0]  pre_len;
  logic        hdr_prog;

  plcm_cpu_model plcm_cpu_model_i (
    .mclk(mclk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .ctrl_stop(ctrl_stop), .bus_rdata(bus_rdata));

  plcm_flags_port plcm_flags_port_i (
    .MCLK(mclk), .ARST_N(arst_n), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata),
    .BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_RDATA(bus_rdata), .CTRL_STOP(ctrl_stop),
    .CTRL_RX_MODE(rx_mode), .CTRL_PRE_LEN(pre_len), .CTRL_FCS_MODE(fcs_mode),
    .CTRL_FEC_MODE(fec_mode), .CTRL_NULL_MODE(null_mode),
    .CTRL_HEADER_PROGRAM_MODE(hdr_prog), .CTRL_TXIE(txie),
    .PREAMBLE_ERROR_LIMIT(pre_lim), .HEADER_ERROR_LIMIT(hdr_lim),
    .MODEM_RX_STROBE(rx_strobe), .MODEM_RX_LEVEL(rx_level), .MODEM_TX_TICK(tx_tick),
    .TX_CHECK_WORD(16'h3c96), .CHECK_SEQ_FAIL(cs_fail), .BLOCK_CODE_FAIL(bc_fail),
    .MODEM_TX_BIT(tx_bit), .MODEM_TX_ACTIVE(tx_active), .EXT_INTERRUPT_LINE(irq));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic end_sim();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] v;
    plcm_cpu_model_i.rd(a, v);
    chk8(v, exp);
  endtask
  task automatic bit_in(input logic [2:0] lvl);
    @(posedge mclk);
    #1;
    rx_strobe = 1'b1;
    rx_level = lvl;
    @(posedge mclk);
    #1;
    rx_strobe = 1'b0;
    rx_level = ~lvl;
  endtask
  // bit pos gets soft level lvl, all others strong
  task automatic bits_in(input logic [15:0] v, input int n, input int pos,
                         input logic [2:0] lvl);
    for (int i = n - 1; i >= 0; i--) begin
      bit_in(i == pos ? lvl : (v[i] ? 3'h7 : 3'h0));
    end
  endtask
  // preamble bit count follows pre_len
  task automatic pkt(input logic [15:0] pre, input logic [15:0] h, input int pos,
                     input logic [2:0] lvl, input logic [7:0] db);
    plcm_cpu_model_i.stop_cycle();
    bits_in(pre, 4 * (int'(pre_len) + 1), -1, 3'h0);
    bits_in(h, 16, pos, lvl);
    bits_in({8'h00, db}, 8, -1, 3'h0);
    repeat (2) @(posedge mclk);
    #1;
  endtask
  // modem line idles between ticks; bits sampled after each tick
  task automatic tx_get(output logic [7:0] b);
    for (int i = 0; i < 20 && tx_active !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk8({7'h0, tx_active}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      #1;
      tx_tick = 1'b1;
      @(posedge mclk);
      #1;
      tx_tick = 1'b0;
      b = {b[6:0], tx_bit};
    end
    chk8({7'h0, tx_active}, 8'h00);
    repeat (2) @(posedge mclk);
    #1;
  endtask

  initial begin
    #(20 * 20000);
    n_mismatch++;
    end_sim();
  end

  initial begin
    hdr_tab = '{16'h9b58, 16'he958, 16'h24e7, 16'ha5d8};
    {rx_strobe, tx_tick, cs_fail, bc_fail, fcs_mode, fec_mode, null_mode, txie} = 8'h00;
    arst_n = 1'b0;
    rx_mode = 1'b1;
    rx_level = 3'h0;
    pre_lim = 6'h00;
    pre_len = 2'b00;
    hdr_prog = 1'b0;
    hdr_lim = 8'h03;
    n_mismatch = 0;
    checks_done = 0;
    repeat (10) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    rchk(16'hfe01, 8'h10);
    rchk(16'hfe02, 8'h00);
    rchk(16'hfe03, 8'h00);
    plcm_cpu_model_i.wr(16'hfe00, 8'hff);
    rchk(16'hfe00, 8'h00);
    plcm_cpu_model_i.wr(16'hfe02, 8'hff);
    rchk(16'hfe02, 8'he0);
    plcm_cpu_model_i.wr(16'hfe01, 8'he4);
    rchk(16'hfe01, 8'h84);
    rx_level = 3'h5;
    rchk(16'hfe03, 8'h05);
    plcm_cpu_model_i.wr(16'hfe03, 8'h01);
    repeat (2) @(posedge mclk);
    #1;
    chk8({7'h0, tx_bit}, 8'h01);
    plcm_cpu_model_i.wr(16'hfe01, 8'h10);
    plcm_cpu_model_i.wr(16'hfe02, 8'h00);
    // soft error of distance i still within the limit
    for (int i = 0; i < 4; i++) begin
      pkt(16'h000a, hdr_tab[i], 5, hdr_tab[i][5] ? 3'(7 - i) : 3'(i), 8'h40 + 8'(i));
      chk8({7'h0, irq}, 8'h01);
      rchk(16'hfe02, 8'(i << 2));
      plcm_cpu_model_i.rx_take(8'h10, d);
      chk8(d, 8'h40 + 8'(i));
      rchk(16'hfe01, 8'h10);
    end
    hdr_lim = 8'h06;
    for (int h = 0; h < 2; h++) begin
      plcm_cpu_model_i.wr(16'hfe02, h ? 8'h80 : 8'h00);
      pkt(16'h000a, 16'h9b58, 15, 3'h3, 8'h00);
      rchk(16'hfe01, h ? 8'h10 : 8'h12);
    end
    plcm_cpu_model_i.wr(16'hfe02, 8'h00);
    pre_lim = 6'h01;
    for (int t = 0; t < 2; t++) begin
      plcm_cpu_model_i.wr(16'hfe01, t ? 8'h10 : 8'h00);
      pkt(16'h0008, 16'h9b58, -1, 3'h0, 8'h00);
      rchk(16'hfe01, t ? 8'h12 : 8'h00);
    end
    // one preamble error plus header score 6: only the sum exceeds 6
    for (int a = 0; a < 2; a++) begin
      plcm_cpu_model_i.wr(16'hfe02, a ? 8'h00 : 8'h20);
      pkt(16'h0008, 16'h9b58, 15, 3'h1, 8'h00);
      rchk(16'hfe01, a ? 8'h12 : 8'h10);
    end
    plcm_cpu_model_i.wr(16'hfe01, 8'h00);
    pre_len = 2'b11;
    for (int p = 0; p < 2; p++) begin
      pkt(p ? 16'haaaa : 16'h00aa, 16'h9b58, -1, 3'h0, 8'h00);
      rchk(16'hfe01, p ? 8'h02 : 8'h00);
    end
    pre_len = 2'b00;
    plcm_cpu_model_i.stop_cycle();
    @(posedge mclk);
    #1;
    cs_fail = 1'b1;
    bc_fail = 1'b1;
    @(posedge mclk);
    #1;
    cs_fail = 1'b0;
    bc_fail = 1'b0;
    rchk(16'hfe02, 8'h03);
    plcm_cpu_model_i.stop_cycle();
    rchk(16'hfe02, 8'h00);
    hdr_tab[3] = 16'h5e21;
    hdr_prog = 1'b1;
    for (int k = 0; k < 8; k++) begin
      plcm_cpu_model_i.wr(16'hfe03, k[0] ? hdr_tab[k / 2][7:0] : hdr_tab[k / 2][15:8]);
    end
    hdr_prog = 1'b0;
    pkt(16'h000a, 16'h5e21, -1, 3'h0, 8'h77);
    rchk(16'hfe02, 8'h0c);
    // null mode first, then fec mode with delivery on
    for (int m = 0; m < 2; m++) begin
      null_mode = (m == 0);
      fec_mode = (m == 1);
      plcm_cpu_model_i.wr(16'hfe01, 8'h14);
      pkt(16'h000a, 16'h24e7, -1, 3'h0, 8'h5a);
      bits_in(16'h002c, 6, -1, 3'h0);
      repeat (2) @(posedge mclk);
      rchk(16'hfe03, m ? 8'h2c : 8'h13);
    end
    null_mode = 1'b0;
    fec_mode = 1'b0;
    rx_mode = 1'b0;
    txie = 1'b1;
    fcs_mode = 1'b1;
    plcm_cpu_model_i.stop_cycle();
    plcm_cpu_model_i.tx_put(8'h10, 8'ha5, ok);
    chk8({7'h0, ok}, 8'h01);
    tx_get(d);
    chk8(d, 8'ha5);
    rchk(16'hfe01, 8'h10);
    // end marker set after the data byte: two check bytes follow
    plcm_cpu_model_i.wr(16'hfe01, 8'h18);
    tx_get(d);
    chk8(d, 8'h3c);
    tx_get(d);
    chk8(d, 8'h96);
    rchk(16'hfe03, 8'h96);
    rchk(16'hfe01, 8'h1a);
    chk8({7'h0, irq}, 8'h01);
    rchk(16'hfe02, 8'h10);
    plcm_cpu_model_i.stop_cycle();
    rchk(16'hfe02, 8'h00);
    rchk(16'hfe01, 8'h10);
    end_sim();
  end
endmodule
`default_nettype wire
